/* File: design/psk_entry.sv */
`timescale 1ns/10ps
`default_nettype none

module psk_entry
	import psk_pkg::*;
(
	// Clock and reset
	input  wire logic      i_clock,
	input  wire logic      i_rst,
	// Stack movement
	input  wire logic      i_shift,
	input  wire psk_page_t i_shift_val,
	// Software write
	input  wire logic      i_wr,
	input  wire psk_page_t i_wr_val,
	// Stored page
	output var  psk_page_t o_q
);

	// Stack movement outranks a software write in the same cycle
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_q <= PSK_PAGE_RESET;
		else if (i_shift)
			o_q <= i_shift_val;
		else if (i_wr)
			o_q <= i_wr_val;
	end

endmodule : psk_entry

`default_nettype wire

/* File: design/psk_page_stack.sv */
// Notes on behaviour
// - Three-level stack: top, middle, bottom entries.
// - Stack shifts only on interrupt entry/return.
// - Middle/bottom writes change only that entry.
// - Bottom write stores value in third entry.
// - Return moves bottom value into middle.
// - Bottom read returns third entry, no effect.
// - Entry pushes top, middle down; loads source page.
// - Return: middle to top, bottom to zero.
// - Auto-page enable gates switching; resets enabled.
`timescale 1ns/10ps
`default_nettype none

module psk_page_stack
	import psk_pkg::*;
(
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	// Special-register bus
	input  wire psk_sfr_req_t i_sfr_req,
	output logic [7:0]        o_sfr_rdata,
	output logic              o_sfr_hit,
	// Interrupt sequencer
	input  wire logic         i_irq_enter,
	input  wire psk_page_t    i_irq_page,
	input  wire logic         i_irq_return,
	// Page state
	output psk_page_t         o_active_page,
	output logic              o_auto_page_switch_en
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	function automatic logic psk_wr_hit(input psk_sfr_req_t req, input logic [7:0] addr);
		return req.wr && (req.addr == addr);
	endfunction : psk_wr_hit

	psk_page_t active_page_select;
	psk_page_t page_stack_middle;
	psk_page_t page_stack_bottom;
	logic      auto_page_switch_en_r;
	logic      push;
	logic      pop;
	logic      wr_top;
	logic      wr_middle;
	logic      wr_bottom;
	logic      wr_ctrl;
	logic      ctrl_visible;

	// Entry beats return if the sequencer ever raises both
	assign push         = i_irq_enter && auto_page_switch_en_r;
	assign pop          = i_irq_return && !i_irq_enter && auto_page_switch_en_r;
	assign ctrl_visible = (active_page_select == PSK_CTRL_PAGE);
	assign wr_top       = psk_wr_hit(i_sfr_req, PSK_ADDR_TOP);
	assign wr_middle    = psk_wr_hit(i_sfr_req, PSK_ADDR_MIDDLE);
	assign wr_bottom    = psk_wr_hit(i_sfr_req, PSK_ADDR_BOTTOM);
	assign wr_ctrl      = psk_wr_hit(i_sfr_req, PSK_ADDR_CTRL) && ctrl_visible;

	////////////////////////////////////////////////////////////////////////
	// Stack entries

	psk_page_t top_shift_val;
	psk_page_t middle_shift_val;
	psk_page_t bottom_shift_val;

	// Shift values for push and pop
	assign top_shift_val    = push ? i_irq_page : page_stack_middle;
	assign middle_shift_val = push ? active_page_select : page_stack_bottom;
	assign bottom_shift_val = push ? page_stack_middle : PSK_PAGE_EMPTY;

	// Top entry, the active page select
	psk_entry u_top
	(
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_shift     (push || pop),
		.i_shift_val (top_shift_val),
		.i_wr        (wr_top),
		.i_wr_val    (i_sfr_req.wdata),
		.o_q         (active_page_select)
	);

	// Middle entry
	psk_entry u_middle
	(
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_shift     (push || pop),
		.i_shift_val (middle_shift_val),
		.i_wr        (wr_middle),
		.i_wr_val    (i_sfr_req.wdata),
		.o_q         (page_stack_middle)
	);

	// Bottom entry
	psk_entry u_bottom
	(
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_shift     (push || pop),
		.i_shift_val (bottom_shift_val),
		.i_wr        (wr_bottom),
		.i_wr_val    (i_sfr_req.wdata),
		.o_q         (page_stack_bottom)
	);

	////////////////////////////////////////////////////////////////////////
	// Control register

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			auto_page_switch_en_r <= PSK_EN_RESET;
		else if (wr_ctrl)
			auto_page_switch_en_r <= i_sfr_req.wdata[PSK_CTRL_EN_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Read port, registered so the bus sees flop outputs

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_sfr_rdata <= PSK_RDATA_IDLE;
			o_sfr_hit   <= 1'b0;
		end
		else if (i_sfr_req.rd)
		begin
			o_sfr_hit   <= 1'b1;
			unique case (i_sfr_req.addr)
				PSK_ADDR_TOP:    o_sfr_rdata <= active_page_select;
				PSK_ADDR_MIDDLE: o_sfr_rdata <= page_stack_middle;
				PSK_ADDR_BOTTOM: o_sfr_rdata <= page_stack_bottom;
				PSK_ADDR_CTRL:
				begin
					o_sfr_rdata <= PSK_RDATA_IDLE;
					o_sfr_rdata[PSK_CTRL_EN_BIT] <= auto_page_switch_en_r;
					o_sfr_hit   <= ctrl_visible;
				end
				default:
				begin
					// Other addresses belong to other blocks on the bus
					o_sfr_rdata <= PSK_RDATA_IDLE;
					o_sfr_hit   <= 1'b0;
				end
			endcase
		end
		else
		begin
			o_sfr_rdata <= PSK_RDATA_IDLE;
			o_sfr_hit   <= 1'b0;
		end
	end

	// Outputs taken straight from the entry and control flops
	assign o_active_page         = active_page_select;
	assign o_auto_page_switch_en = auto_page_switch_en_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking psk_cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	AST_PUSH_TOP: assert property (push |=> active_page_select == $past(i_irq_page))
		else $error("top not loaded with source page on entry");

	AST_PUSH_MIDDLE: assert property (push |=> page_stack_middle == $past(active_page_select))
		else $error("middle not loaded with old top on entry");

	AST_PUSH_BOTTOM: assert property (push |=> page_stack_bottom == $past(page_stack_middle))
		else $error("bottom not loaded with old middle on entry");

	AST_POP_TOP: assert property (pop |=> active_page_select == $past(page_stack_middle))
		else $error("top not restored from middle on return");

	AST_POP_BOTTOM: assert property (pop |=> page_stack_bottom == PSK_PAGE_EMPTY)
		else $error("bottom not emptied on return");

	AST_POP_MIDDLE: assert property ((wr_bottom && !push && !pop) ##1 pop
		|=> page_stack_middle == $past(i_sfr_req.wdata, 2))
		else $error("written bottom value not in middle after return");

	AST_NO_SHIFT: assert property ((!i_irq_enter && !i_irq_return && !wr_bottom)
		|=> $stable(page_stack_bottom))
		else $error("bottom changed without entry, return or write");

	AST_WR_BOTTOM: assert property ((wr_bottom && !push && !pop)
		|=> page_stack_bottom == $past(i_sfr_req.wdata))
		else $error("bottom write not stored");

	AST_WR_MIDDLE_ONLY: assert property ((wr_middle && !wr_top && !push && !pop)
		|=> $stable(active_page_select) && $stable(page_stack_bottom)
		&& page_stack_middle == $past(i_sfr_req.wdata))
		else $error("middle write disturbed other entries");

	AST_RD_BOTTOM: assert property ((i_sfr_req.rd && i_sfr_req.addr == PSK_ADDR_BOTTOM)
		|=> o_sfr_hit && o_sfr_rdata == $past(page_stack_bottom))
		else $error("bottom read wrong");

	AST_RD_MIDDLE: assert property ((i_sfr_req.rd && i_sfr_req.addr == PSK_ADDR_MIDDLE)
		|=> o_sfr_hit && o_sfr_rdata == $past(page_stack_middle))
		else $error("middle read wrong");

	AST_DISABLED: assert property ((!auto_page_switch_en_r && !wr_top && !wr_middle && !wr_bottom)
		|=> $stable(active_page_select) && $stable(page_stack_middle) && $stable(page_stack_bottom))
		else $error("stack moved while auto page switching off");

	AST_POP_SHIFT_MIDDLE: assert property (pop |=> page_stack_middle == $past(page_stack_bottom))
		else $error("middle not loaded from bottom on return");

	AST_RD_IDLE: assert property (!i_sfr_req.rd |=> !o_sfr_hit && o_sfr_rdata == PSK_RDATA_IDLE)
		else $error("read port not idle without a read");

	AST_CTRL_OFF_PAGE: assert property ((psk_wr_hit(i_sfr_req, PSK_ADDR_CTRL) && !ctrl_visible)
		|=> $stable(auto_page_switch_en_r))
		else $error("control write off its page took effect");

endmodule : psk_page_stack

`default_nettype wire

/* File: design/psk_pkg.sv */
package psk_pkg;

	typedef logic [7:0] psk_page_t;

	// Special-register bus request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} psk_sfr_req_t;

	// Register addresses
	localparam logic [7:0] PSK_ADDR_TOP    = 8'h84;
	localparam logic [7:0] PSK_ADDR_MIDDLE = 8'h85;
	localparam logic [7:0] PSK_ADDR_BOTTOM = 8'h86;
	localparam logic [7:0] PSK_ADDR_CTRL   = 8'h96;

	// Page on which the control register lives
	localparam psk_page_t PSK_CTRL_PAGE = 8'h0F;

	// Control register layout
	localparam int unsigned PSK_CTRL_EN_BIT = 0;

	// Reset and fill values
	localparam psk_page_t  PSK_PAGE_RESET  = 8'h00;
	localparam psk_page_t  PSK_PAGE_EMPTY  = 8'h00;
	localparam logic       PSK_EN_RESET    = 1'b1;
	localparam logic [7:0] PSK_RDATA_IDLE  = 8'h00;

endpackage : psk_pkg

/* File: dv/psk_seq_model.sv */
`timescale 1ns/10ps
`default_nettype none

module psk_seq_model
	import psk_pkg::*;
(
	// Command from bench: 0 idle, 1 enter, 2 return
	input  wire logic [1:0] i_cmd,
	input  wire psk_page_t  i_page,
	// Sequencer pulses
	output logic            o_enter,
	output logic            o_return,
	output psk_page_t       o_page
);
	// Enter and return never together; page valid only with enter
	always_comb
	begin
		o_enter  = (i_cmd == 2'h1);
		o_return = (i_cmd == 2'h2);
		o_page   = o_enter ? i_page : ~i_page;
	end
endmodule : psk_seq_model

`default_nettype wire

/* File: dv/tb_psk_page_stack.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_psk_page_stack;
	import psk_pkg::*;
	logic         i_clock;
	logic         i_rst;
	psk_sfr_req_t req;
	logic [1:0]   cmd;
	psk_page_t    pg;
	logic         ent, ret, hit, en;
	psk_page_t    ipg, act;
	logic [7:0]   rdata, e_rd;
	psk_page_t    m_top, m_mid, m_bot;
	logic         m_en, e_hit;
	logic [7:0]   addrs [5] = '{8'h84, 8'h85, 8'h86, 8'h96, 8'h87};
	int           n_errors, n_compared, cyc;

	psk_seq_model i_seq (.i_cmd(cmd), .i_page(pg), .o_enter(ent), .o_return(ret), .o_page(ipg));
	psk_page_stack i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_sfr_req(req), .o_sfr_rdata(rdata),
		.o_sfr_hit(hit), .i_irq_enter(ent), .i_irq_page(ipg), .i_irq_return(ret),
		.o_active_page(act), .o_auto_page_switch_en(en));

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h84: return m_top;
			8'h85: return m_mid;
			8'h86: return m_bot;
			// Enable bit shows on every page; only the hit flag tracks the page
			8'h96: return {7'h00, m_en};
			default: return 8'h00;
		endcase
	endfunction : exp_rd

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// Called at falling edge: check last cycle, drive and predict next
	task automatic step(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d,
		input logic [1:0] c, input psk_page_t p);
		logic push, pop, ctl;
		chk(rdata, e_rd);
		chk({7'h00, hit}, {7'h00, e_hit});
		chk(act, m_top);
		chk({7'h00, en}, {7'h00, m_en});
		req = '{addr: a, wr: w, rd: r, wdata: d};
		cmd = c;
		pg = p;
		push = (c == 2'h1) && m_en;
		pop = (c == 2'h2) && m_en;
		ctl = w && a == 8'h96 && m_top == 8'h0F;
		e_hit = r && (a inside {8'h84, 8'h85, 8'h86} || (a == 8'h96 && m_top == 8'h0F));
		e_rd = r ? exp_rd(a) : 8'h00;
		// Stack movement beats a same-cycle entry write
		if (push)
			{m_top, m_mid, m_bot} = {p, m_top, m_mid};
		else if (pop)
			{m_top, m_mid, m_bot} = {m_mid, m_bot, 8'h00};
		else if (w && a == 8'h84)
			m_top = d;
		else if (w && a == 8'h85)
			m_mid = d;
		else if (w && a == 8'h86)
			m_bot = d;
		if (ctl)
			m_en = d[0];
		@(negedge i_clock);
	endtask : step

	////////////////////////////////////////////////////////////////
	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc > 4000)
		begin
			n_errors++;
			close_out();
		end
	end

	initial
	begin
		i_rst = 1'b1;
		req = '0;
		cmd = 2'h0;
		pg = 8'h00;
		{m_top, m_mid, m_bot, e_rd, e_hit} = '0;
		m_en = 1'b1;
		void'($urandom(95));
		repeat (3) @(negedge i_clock);
		i_rst = 1'b0;
		step(8'h85, 1'b0, 1'b1, 8'h00, 2'h0, 8'h00);
		step(8'h86, 1'b1, 1'b1, 8'hA5, 2'h0, 8'h00);
		step(8'h86, 1'b0, 1'b1, 8'h00, 2'h0, 8'h00);
		step(8'h85, 1'b1, 1'b0, 8'h3C, 2'h2, 8'h00);
		step(8'h85, 1'b0, 1'b1, 8'h00, 2'h0, 8'h00);
		step(8'h84, 1'b1, 1'b0, 8'h0F, 2'h0, 8'h00);
		step(8'h96, 1'b1, 1'b0, 8'h00, 2'h0, 8'h00);
		step(8'h86, 1'b0, 1'b1, 8'h00, 2'h1, 8'h33);
		step(8'h96, 1'b1, 1'b1, 8'h01, 2'h1, 8'h44);
		step(8'h85, 1'b1, 1'b0, 8'hFF, 2'h1, 8'h55);
		// Random mix; half of pushes land on the control page
		repeat (2000)
			step(addrs[$urandom % 5], 1'($urandom), 1'($urandom), 8'($urandom), 2'($urandom % 3),
				($urandom % 2) ? 8'h0F : 8'($urandom));
		step(8'h00, 1'b0, 1'b0, 8'h00, 2'h0, 8'h00);
		close_out();
	end
endmodule : tb_psk_page_stack

`default_nettype wire
